// ---- src/meter_meas_tcomp.sv ----
// interval measurements and temperature compensation with an AXI4-Lite register slave
// What this block does
// (R01) selected phase feeds frequency and edge counter
// (R02) frequency from FLL, LSB Fs over 2^32
// (R03) sum squared current samples per element
// (R04) sum squared voltage samples for element 0
// (R05) report half-cycles of previous interval
// (R06) count both edge directions, debounced
// (R07) deviation is minus slope times 2^-22 times difference
// (R08) deviation positive when hotter than reference
// (R09) software copies raw reading into reference
// (R10) code 15 hands gain to software
// (R11) internal gain is 16384 plus floor of one plus terms
// (R12) reset selects internal compensation
// (R13) linear coefficient scales voltage and current
// (R14) square coefficient scales voltage and current
// (R15) internal mode recomputes gain automatically
// (R16) gain 16384 is unity on all inputs
// (R17) pulse ready, hold results over interval
// (R18) all results update together at interval end
module meter_meas_tcomp
  import meter_pkg::*;
#(
  parameter int DEBOUNCE = 4,
  parameter int FLL_SHIFT = 6,
  parameter logic [31:0] FREQ_INIT = 32'h0515_0000,
  parameter int SUM_SHIFT = 16
)
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire sample_t SAMPLE,
  input wire logic [31:0] TEMP_RAW,
  input wire logic INTERVAL_END,
  output logic XFER_READY,
  output logic [31:0] GAIN_SCALE,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  localparam int SW = SAMPLE_W;

  logic [31:0] temp_ref_ff, temp_slope_ff, comp_src_ff, lin_coeff_ff, sq_coeff_ff, gain_ff;
  logic [1:0] rate_sel_ff;
  logic phase_sel_ff;
  logic [31:0] temp_raw_ff, temp_dev_ff, freq_ff, edge_count_ff;
  logic xfer_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_go, rd_go, wr_hit, ext_mode;
  logic [7:0] wr_idx, rd_idx;

  // ---------------- register bus ----------------
  assign wr_go = AWVALID & WVALID & ~bvalid_ff;
  assign AWREADY = wr_go;
  assign WREADY = wr_go;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign rd_go = ARVALID & ~rvalid_ff;
  assign ARREADY = ~rvalid_ff;
  assign RVALID = rvalid_ff;
  assign RRESP = rresp_ff;
  assign RDATA = rdata_ff;
  assign wr_idx = AWADDR[9:2];
  assign rd_idx = ARADDR[9:2];
  assign ext_mode = (comp_src_ff == EXT_COMP_VALUE);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = dat[8*i +: 8];
    end
    return res;
  endfunction

  always_comb
  begin
    case (wr_idx)
      IDX_TEMP_REF, IDX_TEMP_SLOPE, IDX_COMP_SRC, IDX_LIN_COEFF, IDX_SQ_COEFF,
      IDX_GAIN_SCALE, IDX_RATE_SEL, IDX_PHASE_SEL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (BREADY)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      temp_ref_ff <= RST_TEMP_REF;
      temp_slope_ff <= RST_TEMP_SLOPE;
      comp_src_ff <= RST_COMP_SRC; // [R12]
      lin_coeff_ff <= RST_LIN_COEFF;
      sq_coeff_ff <= RST_SQ_COEFF;
      rate_sel_ff <= RST_RATE_SEL;
      phase_sel_ff <= 1'b0;
    end
    else if (wr_go)
    begin
      case (wr_idx)
        IDX_TEMP_REF: temp_ref_ff <= merge(temp_ref_ff, WDATA, WSTRB); // [R09]
        IDX_TEMP_SLOPE: temp_slope_ff <= merge(temp_slope_ff, WDATA, WSTRB);
        IDX_COMP_SRC: comp_src_ff <= merge(comp_src_ff, WDATA, WSTRB);
        IDX_LIN_COEFF: lin_coeff_ff <= merge(lin_coeff_ff, WDATA, WSTRB);
        IDX_SQ_COEFF: sq_coeff_ff <= merge(sq_coeff_ff, WDATA, WSTRB);
        IDX_RATE_SEL: rate_sel_ff <= WSTRB[0] ? WDATA[1:0] : rate_sel_ff;
        IDX_PHASE_SEL: phase_sel_ff <= WSTRB[0] ? WDATA[0] : phase_sel_ff;
        default: ;
      endcase
    end
  end

  // ---------------- phase selection and debounced crossings ----------------
  logic signed [SW-1:0] sel_volt;
  logic sign_ff, edge_inc, rise_inc;
  logic [7:0] cand_ff;
  assign sel_volt = phase_sel_ff ? SAMPLE.volt1 : SAMPLE.volt0; // [R01]
  assign edge_inc = SAMPLE.valid & (sel_volt[SW-1] != sign_ff)
                    & (cand_ff == 8'(DEBOUNCE - 1)); // [R06]
  assign rise_inc = edge_inc & sign_ff;

  // a crossing must persist DEBOUNCE samples so noise near zero counts once
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sign_ff <= 1'b0;
      cand_ff <= 8'h00;
    end
    else if (SAMPLE.valid)
    begin
      if (edge_inc)
      begin
        sign_ff <= sel_volt[SW-1];
        cand_ff <= 8'h00;
      end
      else if (sel_volt[SW-1] != sign_ff)
        cand_ff <= cand_ff + 8'h01; // [R06]
      else
        cand_ff <= 8'h00;
    end
  end

  logic [31:0] edge_acc_ff, nxt_edge_acc;
  assign nxt_edge_acc = edge_acc_ff + {31'h0, edge_inc}; // [R05]

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      edge_acc_ff <= 32'h0;
    else if (INTERVAL_END)
      edge_acc_ff <= 32'h0;
    else
      edge_acc_ff <= nxt_edge_acc;
  end

  // ---------------- frequency locked loop ----------------
  // nco advances once per sample, so one lsb of the increment is Fs / 2^32
  logic [31:0] nco_ff, nco_inc_ff, last_err_ff;
  logic [31:0] err_diff;
  assign err_diff = nco_ff - last_err_ff;

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      nco_ff <= 32'h0;
      nco_inc_ff <= FREQ_INIT;
      last_err_ff <= 32'h0;
    end
    else if (SAMPLE.valid)
    begin
      nco_ff <= nco_ff + nco_inc_ff; // [R02]
      if (rise_inc)
      begin
        last_err_ff <= nco_ff;
        nco_inc_ff <= nco_inc_ff - 32'($signed(err_diff) >>> FLL_SHIFT); // [R02]
      end
    end
  end

  // ---------------- temperature deviation and gain ----------------
  logic signed [32:0] raw_diff;
  logic signed [65:0] slope_prod;
  logic signed [31:0] tdev_calc;
  logic signed [63:0] lin_term;
  logic signed [63:0] tdev_sq;
  logic signed [99:0] gain_sum;
  logic [31:0] gain_calc;

  always_comb
  begin
    raw_diff = $signed({TEMP_RAW[31], TEMP_RAW}) - $signed({temp_ref_ff[31], temp_ref_ff});
    slope_prod = -($signed({{34{temp_slope_ff[31]}}, temp_slope_ff})
                  * $signed({{33{raw_diff[32]}}, raw_diff})); // [R07]
    // raw reading below reference (hotter) gives positive deviation [R08]
    tdev_calc = 32'(slope_prod >>> TDEV_SHIFT); // [R07]
    lin_term = 64'(tdev_calc) * 64'($signed(lin_coeff_ff)); // [R13]
    tdev_sq = 64'(tdev_calc) * 64'(tdev_calc);
    gain_sum = (100'(lin_term) <<< LIN_ALIGN)
               + 100'(tdev_sq) * 100'($signed(sq_coeff_ff)) // [R14]
               + (100'sd1 <<< SQ_TERM_SHIFT);
    gain_calc = GAIN_UNITY + 32'(gain_sum >>> SQ_TERM_SHIFT); // [R11]
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      gain_ff <= RST_GAIN;
    else if (INTERVAL_END && !ext_mode)
      gain_ff <= gain_calc; // [R15]
    else if (wr_go && wr_idx == IDX_GAIN_SCALE && ext_mode)
      gain_ff <= merge(gain_ff, WDATA, WSTRB); // [R10]
  end
  assign GAIN_SCALE = gain_ff;

  // ---------------- squared sums per channel ----------------
  logic signed [SW-1:0] chan [3];
  assign chan[0] = SAMPLE.cur0;
  assign chan[1] = SAMPLE.cur1;
  assign chan[2] = SAMPLE.volt0;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sum
      logic signed [SW+32:0] prod;
      logic signed [SW+1:0] scaled;
      logic [2*SW+3:0] sq;
      logic [64:0] wide;
      logic [63:0] acc_ff, nxt_acc, shifted;
      logic [31:0] res_ff;
      // gain above four times unity wraps in the scaled sample; compensation stays far below that
      assign prod = (SW+33)'(chan[g]) * (SW+33)'($signed({1'b0, gain_ff})); // [R16]
      assign scaled = prod[SW+1+GAIN_FRAC:GAIN_FRAC]; // [R16]
      // widen before squaring, a self-sized product would drop the upper bits
      assign sq = $unsigned((2*SW+4)'(scaled) * (2*SW+4)'(scaled)); // [R03] [R04]
      assign wide = {1'b0, acc_ff} + 65'(sq);
      assign nxt_acc = !SAMPLE.valid ? acc_ff : (wide[64] ? 64'hffff_ffff_ffff_ffff : wide[63:0]);
      assign shifted = nxt_acc >> SUM_SHIFT;

      always_ff @(posedge CLOCK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          acc_ff <= 64'h0;
          res_ff <= 32'h0;
        end
        else if (INTERVAL_END)
        begin
          acc_ff <= 64'h0;
          // saturate rather than fold back on overflow
          res_ff <= (|shifted[63:31]) ? SUM_SAT : shifted[31:0]; // [R18]
        end
        else
          acc_ff <= nxt_acc;
      end
    end
  endgenerate

  // ---------------- interval results ----------------
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      temp_raw_ff <= 32'h0;
      temp_dev_ff <= 32'h0;
      freq_ff <= 32'h0;
      edge_count_ff <= 32'h0;
    end
    else if (INTERVAL_END)
    begin
      temp_raw_ff <= TEMP_RAW;
      temp_dev_ff <= tdev_calc; // [R07]
      freq_ff <= nco_inc_ff; // [R02]
      edge_count_ff <= nxt_edge_acc; // [R18]
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      xfer_ff <= 1'b0;
    else
      xfer_ff <= INTERVAL_END; // [R17]
  end
  assign XFER_READY = xfer_ff;

  // ---------------- read path ----------------
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0;
    end
    else if (rd_go)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      case (rd_idx)
        IDX_TEMP_REF: rdata_ff <= temp_ref_ff;
        IDX_TEMP_SLOPE: rdata_ff <= temp_slope_ff;
        IDX_COMP_SRC: rdata_ff <= comp_src_ff;
        IDX_LIN_COEFF: rdata_ff <= lin_coeff_ff;
        IDX_SQ_COEFF: rdata_ff <= sq_coeff_ff;
        IDX_GAIN_SCALE: rdata_ff <= gain_ff;
        IDX_RATE_SEL: rdata_ff <= {30'h0, rate_sel_ff};
        IDX_PHASE_SEL: rdata_ff <= {31'h0, phase_sel_ff};
        IDX_TEMP_DEV: rdata_ff <= temp_dev_ff;
        IDX_TEMP_RAW: rdata_ff <= temp_raw_ff;
        IDX_LINE_FREQ: rdata_ff <= freq_ff;
        IDX_CUR_SQ_A: rdata_ff <= g_sum[0].res_ff;
        IDX_CUR_SQ_B: rdata_ff <= g_sum[1].res_ff;
        IDX_VOLT_SQ_A: rdata_ff <= g_sum[2].res_ff;
        IDX_EDGE_CNT: rdata_ff <= edge_count_ff;
        default:
        begin
          rdata_ff <= 32'h0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (RREADY)
      rvalid_ff <= 1'b0;
  end

  // ---------------- checks ----------------
  a_xfer_after_end: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R17]
    INTERVAL_END |=> XFER_READY)
    else $error("ready pulse missing after interval end");

  a_results_hold: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R17]
    !INTERVAL_END |=> $stable(edge_count_ff) && $stable(freq_ff) && $stable(g_sum[0].res_ff)
      && $stable(g_sum[2].res_ff) && $stable(temp_dev_ff))
    else $error("interval result changed mid interval");

  a_edge_latch: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R05]
    INTERVAL_END |=> edge_count_ff == $past(edge_acc_ff) + {31'h0, $past(edge_inc)}
      && edge_acc_ff == 32'h0)
    else $error("edge count not taken at interval end");

  a_debounce_len: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R06]
    edge_inc |-> SAMPLE.valid && cand_ff == 8'(DEBOUNCE - 1) && $past(sel_volt[SW-1] != sign_ff))
    else $error("edge counted without debounce");

  a_gain_internal: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R11]
    INTERVAL_END && !ext_mode |=> gain_ff == $past(gain_calc))
    else $error("internal gain not refreshed");

  a_gain_external: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R10]
    ext_mode && !(wr_go && wr_idx == IDX_GAIN_SCALE) |=> $stable(gain_ff))
    else $error("gain moved in external mode");

  a_tdev_sign: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R08]
    INTERVAL_END && $signed(TEMP_RAW) < $signed(temp_ref_ff) && temp_ref_ff[31] == TEMP_RAW[31]
      && $signed(temp_slope_ff) > 0 && temp_slope_ff < 32'h0001_0000
      |=> $signed(temp_dev_ff) >= 0)
    else $error("deviation negative while hotter");

  a_unity_sum: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R16]
    gain_ff == GAIN_UNITY |-> g_sum[2].scaled == (SW+2)'(chan[2]))
    else $error("unity gain changed a sample");

  a_bus_answer: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_go |=> BVALID) and (rd_go |=> RVALID) and (BVALID && !BREADY |=> BVALID))
    else $error("bus answer timing broken");

  c_interval_edges: cover property (@(posedge CLOCK) disable iff (!RSTN)
    INTERVAL_END && edge_acc_ff > 32'h1);
  c_ext_gain_write: cover property (@(posedge CLOCK) disable iff (!RSTN)
    ext_mode && wr_go && wr_idx == IDX_GAIN_SCALE);
  c_freq_read: cover property (@(posedge CLOCK) disable iff (!RSTN)
    rd_go && rd_idx == IDX_LINE_FREQ);
endmodule

// ---- src/meter_pkg.sv ----
// constants, register map and carrier types for the measurement and compensation block
package meter_pkg;
  localparam int SAMPLE_W = 24;
  localparam int ADDR_W = 10;

  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_TEMP_REF = 8'h11;
  localparam logic [7:0] IDX_GAIN_SCALE = 8'h2e;
  localparam logic [7:0] IDX_TEMP_SLOPE = 8'h30;
  localparam logic [7:0] IDX_COMP_SRC = 8'h38;
  localparam logic [7:0] IDX_LIN_COEFF = 8'h39;
  localparam logic [7:0] IDX_SQ_COEFF = 8'h3a;
  localparam logic [7:0] IDX_TEMP_DEV = 8'h40;
  localparam logic [7:0] IDX_LINE_FREQ = 8'h41;
  localparam logic [7:0] IDX_CUR_SQ_A = 8'h4a;
  localparam logic [7:0] IDX_CUR_SQ_B = 8'h4b;
  localparam logic [7:0] IDX_VOLT_SQ_A = 8'h4e;
  localparam logic [7:0] IDX_TEMP_RAW = 8'h54;
  localparam logic [7:0] IDX_EDGE_CNT = 8'h55;
  localparam logic [7:0] IDX_RATE_SEL = 8'h60;
  localparam logic [7:0] IDX_PHASE_SEL = 8'h61;

  // reset values
  localparam logic [31:0] RST_TEMP_REF = 32'h0000_0000;
  localparam logic [31:0] RST_TEMP_SLOPE = 32'h0000_2571;
  localparam logic [31:0] RST_COMP_SRC = 32'h0000_0000;
  localparam logic [31:0] RST_LIN_COEFF = 32'h0000_0000;
  localparam logic [31:0] RST_SQ_COEFF = 32'h0000_0000;
  localparam logic [31:0] RST_GAIN = 32'h0000_4000;
  localparam logic [1:0] RST_RATE_SEL = 2'h1;

  // arithmetic layout
  localparam logic [31:0] EXT_COMP_VALUE = 32'h0000_000f;
  localparam logic [31:0] GAIN_UNITY = 32'h0000_4000;
  localparam int GAIN_FRAC = 14;
  localparam int TDEV_SHIFT = 22;
  localparam int SQ_TERM_SHIFT = 23;
  localparam int LIN_ALIGN = SQ_TERM_SHIFT - GAIN_FRAC;
  localparam logic [31:0] SUM_SAT = 32'h7fff_ffff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic signed [SAMPLE_W-1:0] cur0;
    logic signed [SAMPLE_W-1:0] cur1;
    logic signed [SAMPLE_W-1:0] volt0;
    logic signed [SAMPLE_W-1:0] volt1;
  } sample_t;
endpackage

// ---- dv/tb.sv ----
// self-checking bench for the measurement and temperature compensation block
module tb
  import meter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 4;
  localparam int SUM_SH = 4;
  localparam logic [31:0] F_INIT = 32'h0515_0000;
  localparam logic [23:0] VP = 24'h001388;
  localparam logic [23:0] VN = 24'hffec78;
  logic clock;
  logic rstn;
  sample_t sample;
  logic [31:0] temp_raw;
  logic interval_end;
  logic xfer_ready;
  logic [31:0] gain_scale;
  logic [ADDR_W-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ADDR_W-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  int err_count;
  int num_checks;
  logic [3:0] strb_sel;

  meter_meas_tcomp #(.DEBOUNCE(DEB), .FREQ_INIT(F_INIT), .SUM_SHIFT(SUM_SH)) dut_u (
    .CLOCK(clock), .RSTN(rstn), .SAMPLE(sample), .TEMP_RAW(temp_raw),
    .INTERVAL_END(interval_end), .XFER_READY(xfer_ready), .GAIN_SCALE(gain_scale),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] rexp);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= strb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (!(awready === 1'b1 && wready === 1'b1) && n < 50);
    if (n >= 50)
      err_count++;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    if (n >= 50)
      err_count++;
    chk("write resp", {30'h0, bresp}, {30'h0, rexp});
    bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] rexp);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (arready !== 1'b1 && n < 50);
    if (n >= 50)
      err_count++;
    arvalid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    if (n >= 50)
      err_count++;
    chk($sformatf("reg %h", idx), rdata, exp);
    chk("read resp", {30'h0, rresp}, {30'h0, rexp});
    rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic smp(input int n, input logic [23:0] c0, c1, v0, v1);
    sample <= '{1'b1, c0, c1, v0, v1};
    repeat (n) @(posedge clock);
    sample.valid <= 1'b0;
    @(posedge clock);
  endtask

  // ready must pulse for exactly one cycle with the gain already updated
  task automatic tick(input logic [31:0] g);
    interval_end <= 1'b1;
    @(posedge clock);
    interval_end <= 1'b0;
    @(negedge clock);
    chk("xfer ready", {31'h0, xfer_ready}, 32'h1);
    chk("gain port", gain_scale, g);
    @(posedge clock);
    @(negedge clock);
    chk("xfer ready low", {31'h0, xfer_ready}, 32'h0);
    @(posedge clock);
  endtask

  // floor(1 + lin term + square term) folded into a single flooring shift
  function automatic logic [31:0] gexp(input longint t, input longint l, input longint s);
    return 32'(64'sd16384 + ((t * l * 512 + t * t * s + 64'sd8388608) >>> 23));
  endfunction

  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    give_verdict();
  end

  initial
  begin
    err_count = 0;
    num_checks = 0;
    strb_sel = 4'hf;
    rstn = 1'b0;
    sample = '0;
    temp_raw = 32'h0;
    interval_end = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("gain port", gain_scale, 32'h0000_4000);
    rchk(IDX_COMP_SRC, 32'h0, RESP_OKAY);
    rchk(IDX_TEMP_REF, 32'h0, RESP_OKAY);
    rchk(IDX_TEMP_SLOPE, 32'h0000_2571, RESP_OKAY);
    rchk(IDX_LIN_COEFF, 32'h0, RESP_OKAY);
    rchk(IDX_SQ_COEFF, 32'h0, RESP_OKAY);
    rchk(IDX_GAIN_SCALE, 32'h0000_4000, RESP_OKAY);
    rchk(IDX_RATE_SEL, 32'h1, RESP_OKAY);
    wr(IDX_RATE_SEL, 32'h2, RESP_OKAY);
    rchk(IDX_RATE_SEL, 32'h2, RESP_OKAY);
    tick(gexp(0, 0, 0));
    rchk(IDX_LINE_FREQ, F_INIT, RESP_OKAY);
    rchk(8'h00, 32'h0, RESP_SLVERR);
    wr(IDX_LINE_FREQ, 32'h1234_5678, RESP_SLVERR);
    rchk(IDX_LINE_FREQ, F_INIT, RESP_OKAY);
    wr(IDX_GAIN_SCALE, 32'h0000_5000, RESP_OKAY);
    rchk(IDX_GAIN_SCALE, gexp(0, 0, 0), RESP_OKAY);
    // only the enabled byte lane lands
    strb_sel = 4'h1;
    wr(IDX_TEMP_REF, 32'hffff_ff55, RESP_OKAY);
    strb_sel = 4'hf;
    rchk(IDX_TEMP_REF, 32'h0000_0055, RESP_OKAY);
    // raw below the reference means hotter
    wr(IDX_TEMP_REF, 32'h0100_0000, RESP_OKAY);
    temp_raw <= 32'h00c0_0000;
    wr(IDX_LIN_COEFF, 32'h10, RESP_OKAY);
    tick(gexp(9585, 16, 0));
    rchk(IDX_TEMP_DEV, 32'h0000_2571, RESP_OKAY);
    rchk(IDX_TEMP_RAW, 32'h00c0_0000, RESP_OKAY);
    wr(IDX_LIN_COEFF, 32'h0, RESP_OKAY);
    wr(IDX_SQ_COEFF, 32'h1, RESP_OKAY);
    temp_raw <= 32'h0140_0000;
    tick(gexp(-9585, 0, 1));
    rchk(IDX_TEMP_DEV, 32'hffff_da8f, RESP_OKAY);
    // software owns the gain from here on
    wr(IDX_COMP_SRC, EXT_COMP_VALUE, RESP_OKAY);
    wr(IDX_GAIN_SCALE, 32'h0000_4000, RESP_OKAY);
    chk("gain port", gain_scale, 32'h0000_4000);
    smp(3, 24'h0003e8, 24'hfff830, 24'h00012c, VP);
    tick(32'h0000_4000);
    rchk(IDX_CUR_SQ_A, 32'(64'd3000000 >> SUM_SH), RESP_OKAY);
    rchk(IDX_CUR_SQ_B, 32'(64'd12000000 >> SUM_SH), RESP_OKAY);
    rchk(IDX_VOLT_SQ_A, 32'(64'd270000 >> SUM_SH), RESP_OKAY);
    smp(1, 24'h7fffff, 24'h0, VP, VP);
    rchk(IDX_CUR_SQ_A, 32'(64'd3000000 >> SUM_SH), RESP_OKAY);
    tick(32'h0000_4000);
    rchk(IDX_CUR_SQ_A, 32'h7fff_ffff, RESP_OKAY);
    rchk(IDX_CUR_SQ_B, 32'h0, RESP_OKAY);
    // two debounced crossings, then a glitch one sample too short
    smp(DEB, 24'h0, 24'h0, VN, VP);
    smp(DEB, 24'h0, 24'h0, VP, VP);
    smp(DEB - 1, 24'h0, 24'h0, VN, VP);
    smp(2, 24'h0, 24'h0, VP, VP);
    tick(32'h0000_4000);
    rchk(IDX_EDGE_CNT, 32'h2, RESP_OKAY);
    // the other phase toggles three times, the selected one twice
    wr(IDX_PHASE_SEL, 32'h1, RESP_OKAY);
    rchk(IDX_PHASE_SEL, 32'h1, RESP_OKAY);
    smp(DEB, 24'h0, 24'h0, VN, VN);
    smp(DEB, 24'h0, 24'h0, VP, VN);
    smp(DEB, 24'h0, 24'h0, VN, VP);
    tick(32'h0000_4000);
    rchk(IDX_EDGE_CNT, 32'h2, RESP_OKAY);
    wr(IDX_GAIN_SCALE, 32'h0000_6000, RESP_OKAY);
    chk("gain port", gain_scale, 32'h0000_6000);
    // a second reset must return control to the internal loop
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("gain port", gain_scale, 32'h0000_4000);
    rchk(IDX_COMP_SRC, 32'h0, RESP_OKAY);
    give_verdict();
  end
endmodule
